// File: csmc_addr_chk.v
// Purpose: Address checks for the initial address message
// Assumes: Combinational, fed from the transmit request
// Notes: Country code digits sit at the front of the digit field
`timescale 1ns/1ps
`default_nettype none
`include "csmc_consts.vh"
module csmc_addr_chk #(
   parameter CCW = 4 // Width of country code digit count
) (
   // Address qualifiers
   input wire has_cc,
   input wire special_op,
   input wire to_incoming,
   input wire [CCW-1:0] cc_len,
   input wire [3:0] digit_cnt,
   // Indicators from a preceding system
   input wire ec_known,
   input wire ec_in,
   input wire noc_known,
   input wire noc_in,
   // Results
   output wire digits_ok,
   output wire [7:0] skip_bits,
   output wire ec_eff,
   output wire noc_eff
);
   // Minimum digit count when a country code is present, unless special operator
   assign digits_ok = !has_cc || special_op ||
                      (digit_cnt >= `CSMC_MIN_DIGITS);
   // Full-width product, cut to the 8-bit skip width on purpose
   wire [31:0] cc_bits;
   assign cc_bits = cc_len * `CSMC_DIG_BITS;
   // Country code omitted toward an incoming exchange
   assign skip_bits = (to_incoming && has_cc) ? cc_bits[7:0]
                      : 8'h00;
   // No positive knowledge means no
   assign ec_eff = ec_known & ec_in;
   assign noc_eff = noc_known & noc_in;
endmodule // csmc_addr_chk
`default_nettype wire

// File: csmc_classify.v
// Purpose: Map a heading code pair onto a message class
// Assumes: Pure combinational, used by encoder and decoder
// Notes: Any pair not listed comes back unknown
`timescale 1ns/1ps
`default_nettype none
`include "csmc_consts.vh"
module csmc_classify (
   // Heading pair
   input wire [3:0] group_heading_code,
   input wire [3:0] signal_heading_code,
   // Result
   output reg [3:0] cls,
   output reg known
);
   // Class lookup; spare codes fall to none
   always @* begin
      cls = `CSMC_C_NONE;
      case (group_heading_code)
         `CSMC_G_ADDR: begin
            if (signal_heading_code == `CSMC_S_IAM)
               cls = `CSMC_C_IAM;
            else if (signal_heading_code == `CSMC_S_SAM)
               cls = `CSMC_C_SAM;
            else if (signal_heading_code == `CSMC_S_SAM1)
               cls = `CSMC_C_SAM1;
         end
         `CSMC_G_SUCC: begin
            // Both nibbles needed here
            if (signal_heading_code == `CSMC_S_ACM)
               cls = `CSMC_C_ACM;
            else if (signal_heading_code == `CSMC_S_CHG)
               cls = `CSMC_C_CHG;
         end
         `CSMC_G_FAIL: begin
            if (signal_heading_code == `CSMC_S_EXT)
               cls = `CSMC_C_FAILX;
            else if (signal_heading_code != `CSMC_S_SPARE &&
                     signal_heading_code <= `CSMC_S_FAIL_HI)
               cls = `CSMC_C_FAIL;
         end
         `CSMC_G_CSUP: begin
            if (signal_heading_code == `CSMC_S_EXT)
               cls = `CSMC_C_ANSX;
            else if (signal_heading_code != `CSMC_S_SPARE &&
                     signal_heading_code <= `CSMC_S_CSUP_HI)
               cls = `CSMC_C_CSUP;
         end
         `CSMC_G_CIRC: begin
            if (signal_heading_code != `CSMC_S_SPARE &&
                signal_heading_code <= `CSMC_S_CIRC_HI)
               cls = `CSMC_C_CIRC;
         end
         default: cls = `CSMC_C_NONE;
      endcase
      known = (cls != `CSMC_C_NONE);
   end
endmodule // csmc_classify
`default_nettype wire

// File: csmc_codec.v
// Purpose: Serial encoder and decoder for call signalling messages
// Assumes: Peer logic runs on mclk; serial bits qualified by valid
// Notes: Payload beyond the header is passed as opaque bits, except initial address payload on transmit
`timescale 1ns/1ps
`default_nettype none
`include "csmc_consts.vh"
module csmc_codec #(
   parameter PAYW = 128, // Largest payload in bits
   parameter CCW = 4 // Width of country code digit count
) (
   // Clock and reset
   input wire mclk,
   input wire reset,
   // Transmit request
   input wire tx_start,
   input wire [39:0] tx_label,
   input wire [3:0] tx_group,
   input wire [3:0] tx_signal,
   input wire [PAYW-1:0] tx_payload,
   input wire [7:0] tx_pay_len,
   input wire tx_final,
   input wire tx_call_clear,
   // Address qualifiers for initial address
   input wire tx_has_cc,
   input wire tx_special_op,
   input wire tx_to_incoming,
   input wire [CCW-1:0] tx_cc_len,
   input wire [3:0] tx_digit_cnt,
   input wire tx_ec_known,
   input wire tx_ec_in,
   input wire tx_noc_known,
   input wire tx_noc_in,
   // Continuity status
   input wire cont_pending,
   // Transmit status
   output reg tx_ready,
   output reg tx_refused,
   output reg tx_holding,
   // Serial out
   output reg ser_bit,
   output reg ser_valid,
   output reg ser_sof,
   output reg ser_eof,
   // Serial in
   input wire rx_bit,
   input wire rx_valid,
   input wire rx_sof,
   input wire rx_eof,
   // Decoded header
   output reg [39:0] rx_label,
   output reg [3:0] rx_group,
   output reg [3:0] rx_signal,
   output reg [3:0] rx_class,
   output reg rx_msg_valid,
   output reg rx_unrecog,
   output reg rx_seize,
   output reg rx_short,
   // Received payload bits
   output reg rx_pay_bit,
   output reg rx_pay_valid
);
   // Encoder state
   reg [1:0] st_r;
   reg [1:0] st_nxt;
   reg [47:0] sh_r; // Header shifter
   reg [PAYW-1:0] pay_r; // Payload shifter
   reg [7:0] cnt_r; // Bit counter
   reg [7:0] plen_r; // Payload length held
   reg call_r; // Initial address already sent

   // Classifier and address check results for the request
   wire [3:0] tx_cls;
   wire tx_known;
   wire dig_ok;
   wire [7:0] skip_bits;
   wire ec_eff;
   wire noc_eff;

   // Decoder state
   reg [5:0] rcnt_r; // Header bits taken
   reg in_msg_r; // Inside a received frame
   reg hdr_done_r; // Header fully taken
   reg [47:0] rsh_r; // Received header bits

   // Decoder classifier
   wire [3:0] rx_cls;
   wire rx_known;
   wire [47:0] rsh_nxt;

   // Request classifier, refuses spares
   csmc_classify u_tx_cls (
      .group_heading_code(tx_group),
      .signal_heading_code(tx_signal),
      .cls(tx_cls),
      .known(tx_known)
   );

   // Address digit checks for initial address
   csmc_addr_chk #(
      .CCW(CCW)
   ) u_addr (
      .has_cc(tx_has_cc),
      .special_op(tx_special_op),
      .to_incoming(tx_to_incoming),
      .cc_len(tx_cc_len),
      .digit_cnt(tx_digit_cnt),
      .ec_known(tx_ec_known),
      .ec_in(tx_ec_in),
      .noc_known(tx_noc_known),
      .noc_in(tx_noc_in),
      .digits_ok(dig_ok),
      .skip_bits(skip_bits),
      .ec_eff(ec_eff),
      .noc_eff(noc_eff)
   );

   // Request sorts
   wire is_iam = (tx_cls == `CSMC_C_IAM);
   wire is_sam = (tx_cls == `CSMC_C_SAM) || (tx_cls == `CSMC_C_SAM1);
   // Refusal: spare code, address before seizure, short address
   wire refuse = !tx_known || (is_sam && !call_r) ||
                 (is_iam && !dig_ok);
   // Final digits wait while continuity is open
   wire must_hold = is_sam && tx_final && cont_pending;
   wire accept = tx_start && (st_r == `CSMC_ST_IDLE) && !refuse;

   // Initial address payload with country code dropped
   wire [PAYW-1:0] dig_part;
   wire [PAYW-1:0] iam_pay;
   assign dig_part = (tx_payload >> (`CSMC_DIG_POS + skip_bits))
                     << `CSMC_DIG_POS;
   // Indicator bits forced to the safe value when unknown
   assign iam_pay = dig_part |
                    ({{(PAYW-1){1'b0}}, ec_eff} << `CSMC_EC_POS) |
                    ({{(PAYW-1){1'b0}}, noc_eff} << `CSMC_NOC_POS);

   // Encoder next state
   always @* begin
      st_nxt = st_r;
      case (st_r)
         `CSMC_ST_IDLE: begin
            if (accept)
               st_nxt = must_hold ? `CSMC_ST_HOLD : `CSMC_ST_HDR;
         end
         `CSMC_ST_HOLD: begin
            // Released only once continuity is confirmed
            if (!cont_pending)
               st_nxt = `CSMC_ST_HDR;
         end
         `CSMC_ST_HDR: begin
            if (cnt_r[5:0] == `CSMC_HDR_LAST)
               st_nxt = (plen_r == 8'h00) ? `CSMC_ST_IDLE
                                          : `CSMC_ST_PAY;
         end
         `CSMC_ST_PAY: begin
            if (cnt_r == plen_r - 8'h01)
               st_nxt = `CSMC_ST_IDLE;
         end
         default: st_nxt = `CSMC_ST_IDLE;
      endcase
   end

   // Encoder registers and serial output
   always @(posedge mclk) begin
      if (reset) begin
         st_r <= `CSMC_ST_IDLE;
         sh_r <= 48'h000000000000;
         pay_r <= {PAYW{1'b0}};
         cnt_r <= 8'h00;
         plen_r <= 8'h00;
         call_r <= 1'b0;
         tx_ready <= 1'b0;
         tx_refused <= 1'b0;
         tx_holding <= 1'b0;
         ser_bit <= 1'b0;
         ser_valid <= 1'b0;
         ser_sof <= 1'b0;
         ser_eof <= 1'b0;
      end else begin
         st_r <= st_nxt;
         tx_ready <= (st_nxt == `CSMC_ST_IDLE);
         tx_holding <= (st_nxt == `CSMC_ST_HOLD);
         tx_refused <= tx_start && (st_r == `CSMC_ST_IDLE) && refuse;
         ser_valid <= 1'b0;
         ser_sof <= 1'b0;
         ser_eof <= 1'b0;
         // Call tracking: set by seizure, else cleared by user
         if (accept && is_iam)
            call_r <= 1'b1;
         else if (tx_call_clear)
            call_r <= 1'b0;
         case (st_r)
            `CSMC_ST_IDLE: begin
               cnt_r <= 8'h00;
               if (accept) begin
                  // Label, group, signal; label bit 0 leaves first
                  sh_r <= {tx_signal, tx_group, tx_label};
                  if (is_iam) begin
                     pay_r <= iam_pay;
                     plen_r <= tx_pay_len - skip_bits;
                  end else begin
                     // Payload of every other message is sent untouched
                     pay_r <= tx_payload;
                     plen_r <= tx_pay_len;
                  end
               end
            end
            `CSMC_ST_HOLD: begin
               cnt_r <= 8'h00;
            end
            `CSMC_ST_HDR: begin
               ser_bit <= sh_r[0];
               ser_valid <= 1'b1;
               ser_sof <= (cnt_r == 8'h00);
               ser_eof <= (cnt_r[5:0] == `CSMC_HDR_LAST) &&
                          (plen_r == 8'h00);
               sh_r <= {1'b0, sh_r[47:1]};
               if (cnt_r[5:0] == `CSMC_HDR_LAST)
                  cnt_r <= 8'h00;
               else
                  cnt_r <= cnt_r + 8'h01;
            end
            `CSMC_ST_PAY: begin
               // Message fields follow the header
               ser_bit <= pay_r[0];
               ser_valid <= 1'b1;
               ser_eof <= (cnt_r == plen_r - 8'h01);
               pay_r <= {1'b0, pay_r[PAYW-1:1]};
               cnt_r <= cnt_r + 8'h01;
            end
            default: cnt_r <= 8'h00;
         endcase
      end
   end

   // Decoder header assembly, first bit lands in bit 0
   assign rsh_nxt = {rx_bit, rsh_r[47:1]};

   // Classify the completed header
   csmc_classify u_rx_cls (
      .group_heading_code(rsh_nxt[43:40]),
      .signal_heading_code(rsh_nxt[47:44]),
      .cls(rx_cls),
      .known(rx_known)
   );

   // Decoder: header take, classification, payload pass
   always @(posedge mclk) begin
      if (reset) begin
         rcnt_r <= 6'h00;
         in_msg_r <= 1'b0;
         hdr_done_r <= 1'b0;
         rsh_r <= 48'h000000000000;
         rx_label <= 40'h0000000000;
         rx_group <= 4'h0;
         rx_signal <= 4'h0;
         rx_class <= `CSMC_C_NONE;
         rx_msg_valid <= 1'b0;
         rx_unrecog <= 1'b0;
         rx_seize <= 1'b0;
         rx_short <= 1'b0;
         rx_pay_bit <= 1'b0;
         rx_pay_valid <= 1'b0;
      end else begin
         rx_msg_valid <= 1'b0;
         rx_unrecog <= 1'b0;
         rx_seize <= 1'b0;
         rx_short <= 1'b0;
         rx_pay_valid <= 1'b0;
         if (rx_valid) begin
            if (rx_sof) begin
               // Frame start restarts the header
               rsh_r <= rsh_nxt;
               rcnt_r <= 6'h01;
               hdr_done_r <= 1'b0;
               in_msg_r <= !rx_eof;
               rx_short <= rx_eof;
            end else if (in_msg_r && !hdr_done_r) begin
               rsh_r <= rsh_nxt;
               rcnt_r <= rcnt_r + 6'h01;
               if (rcnt_r == `CSMC_HDR_LAST) begin
                  hdr_done_r <= 1'b1;
                  rx_label <= rsh_nxt[39:0];
                  rx_group <= rsh_nxt[43:40];
                  rx_signal <= rsh_nxt[47:44];
                  rx_class <= rx_cls;
                  // Spare pairs raise a flag and load the header fields, nothing else
                  rx_msg_valid <= rx_known;
                  rx_unrecog <= !rx_known;
                  // Initial address itself seizes the circuit
                  rx_seize <= (rx_cls == `CSMC_C_IAM);
               end else if (rx_eof) begin
                  rx_short <= 1'b1;
               end
               if (rx_eof)
                  in_msg_r <= 1'b0;
            end else if (in_msg_r) begin
               // Payload of recognised messages only
               rx_pay_bit <= rx_bit;
               rx_pay_valid <= (rx_class != `CSMC_C_NONE);
               if (rx_eof)
                  in_msg_r <= 1'b0;
            end
         end
      end
   end
endmodule // csmc_codec
`default_nettype wire

// File: csmc_codec_props.sv
// Purpose: Port-level properties of the message codec
// Assumes: Bound to csmc_codec; one clock domain
// Notes: Spare heading pairs must be refused or flagged
`timescale 1ns/1ps
`default_nettype none
module csmc_codec_chk (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Transmit side
   input wire logic tx_start,
   input wire logic tx_ready,
   input wire logic [39:0] tx_label,
   input wire logic [3:0] tx_group,
   input wire logic [3:0] tx_signal,
   input wire logic tx_has_cc,
   input wire logic tx_special_op,
   input wire logic [3:0] tx_digit_cnt,
   input wire logic cont_pending,
   input wire logic tx_refused,
   input wire logic tx_holding,
   input wire logic ser_bit,
   input wire logic ser_valid,
   input wire logic ser_sof,
   // Receive side
   input wire logic rx_msg_valid,
   input wire logic rx_unrecog,
   input wire logic rx_seize,
   input wire logic [3:0] rx_signal,
   input wire logic [3:0] rx_group,
   input wire logic [3:0] rx_class
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (reset);
   // Request taken at this edge
   wire logic take = tx_start & tx_ready;
   AST_FAIL_SPARE: assert property (take && tx_group == 4'h5 &&
      (tx_signal == 4'h0 || tx_signal inside {[4'hA:4'hE]}) |=> tx_refused)
      else $error("spare failure code accepted");
   AST_CSUP_SPARE: assert property (take && tx_group == 4'h6 &&
      (tx_signal == 4'h0 || tx_signal inside {[4'h7:4'hE]}) |=> tx_refused)
      else $error("spare supervision code accepted");
   AST_CHG_SENDS: assert property (take && tx_group == 4'h4 &&
      tx_signal == 4'h2 |=> !tx_refused ##1 ser_valid && ser_sof)
      else $error("charging message not sent");
   AST_LABEL_FIRST: assert property (take && tx_group == 4'h6 &&
      tx_signal == 4'h1 |-> ##2 ser_sof && ser_bit == $past(tx_label[0], 2))
      else $error("frame does not open with label bit 0");
   AST_IAM_SHORT: assert property (take && tx_group == 4'h1 &&
      tx_signal == 4'h1 && tx_has_cc && !tx_special_op &&
      tx_digit_cnt < 4'h4 |=> tx_refused) else $error("short address sent");
   AST_HOLD: assert property (tx_holding && cont_pending |=>
      tx_holding && !ser_valid) else $error("digits left before continuity");
   AST_UNRECOG: assert property (rx_unrecog |->
      !rx_msg_valid && !rx_seize) else $error("spare pair acted upon");
   AST_SEIZE: assert property (rx_seize |->
      rx_msg_valid && rx_class == 4'h1) else $error("seize without address");
   AST_ADDR_SPLIT: assert property (rx_msg_valid && rx_group == 4'h4 |->
      rx_class == (rx_signal == 4'h1 ? 4'h4 : 4'h5))
      else $error("group 4 classed wrongly");
endmodule // csmc_codec_chk
bind csmc_codec csmc_codec_chk u_csmc_codec_chk (.*);
`default_nettype wire

// File: csmc_consts.vh
// Purpose: Shared constants of the call signalling message codec
// Assumes: Included by every codec design file
// Notes: Heading codes travel bit 0 first after the label
`ifndef CSMC_CONSTS_VH
`define CSMC_CONSTS_VH

// Field widths of the message header
`define CSMC_LABEL_W 40
`define CSMC_HDR_W 48
`define CSMC_HDR_LAST 6'h2F
`define CSMC_LBL_LAST 6'h27
`define CSMC_GRP_LAST 6'h2B

// Group heading codes
`define CSMC_G_ADDR 4'h1
`define CSMC_G_SUCC 4'h4
`define CSMC_G_FAIL 4'h5
`define CSMC_G_CSUP 4'h6
`define CSMC_G_CIRC 4'h7

// Signal heading codes
`define CSMC_S_SPARE 4'h0
`define CSMC_S_IAM 4'h1
`define CSMC_S_SAM 4'h3
`define CSMC_S_SAM1 4'h4
`define CSMC_S_ACM 4'h1
`define CSMC_S_CHG 4'h2
`define CSMC_S_FAIL_HI 4'h9
`define CSMC_S_EXT 4'hF
`define CSMC_S_CSUP_HI 4'h6
`define CSMC_S_CIRC_HI 4'h7

// Message classes reported by the classifier
`define CSMC_C_NONE 4'h0
`define CSMC_C_IAM 4'h1
`define CSMC_C_SAM 4'h2
`define CSMC_C_SAM1 4'h3
`define CSMC_C_ACM 4'h4
`define CSMC_C_CHG 4'h5
`define CSMC_C_FAIL 4'h6
`define CSMC_C_FAILX 4'h7
`define CSMC_C_CSUP 4'h8
`define CSMC_C_ANSX 4'h9
`define CSMC_C_CIRC 4'hA

// Address field layout inside the payload
`define CSMC_MIN_DIGITS 4'h4
`define CSMC_EC_POS 0
`define CSMC_NOC_POS 1
`define CSMC_DIG_POS 8
`define CSMC_DIG_BITS 4

// Encoder states
`define CSMC_ST_IDLE 2'h0
`define CSMC_ST_HOLD 2'h1
`define CSMC_ST_HDR 2'h2
`define CSMC_ST_PAY 2'h3

`endif

// File: csmc_peer.sv
// Purpose: Peer exchange model on the serial lines
// Assumes: Same clock as the codec; bench hands it frames
// Notes: Idle receive line toggles so stale bits never match
`timescale 1ns/1ps
`default_nettype none
module csmc_peer (
   // Clock and reset
   input wire logic mclk,
   input wire logic reset,
   // Frame request
   input wire logic go,
   input wire logic slow,
   input wire logic [63:0] frame,
   input wire logic [6:0] nbits,
   output logic busy,
   // Lines into the codec
   output logic rx_bit,
   output logic rx_valid,
   output logic rx_sof,
   output logic rx_eof,
   // Lines from the codec
   input wire logic ser_bit,
   input wire logic ser_valid,
   input wire logic ser_sof,
   input wire logic ser_eof,
   // Captured frame
   output logic [79:0] got,
   output logic got_done
);
   logic [63:0] sh_r; // Bits still to send
   logic [6:0] left_r; // Bits left
   logic first_r, gap_r; // Frame opener, stall slot
   logic [6:0] gi_r; // Capture index
   // Sender, first bit first; slow mode stalls every other slot
   always @(posedge mclk) begin
      rx_valid <= 1'b0;
      rx_sof <= 1'b0;
      rx_eof <= 1'b0;
      rx_bit <= ~rx_bit;
      gap_r <= slow & ~gap_r;
      if (reset) begin
         busy <= 1'b0;
         rx_bit <= 1'b0;
      end else if (go & ~busy) begin
         sh_r <= frame;
         left_r <= nbits;
         first_r <= 1'b1;
         busy <= 1'b1;
      end else if (busy & ~gap_r) begin
         rx_bit <= sh_r[0];
         rx_valid <= 1'b1;
         rx_sof <= first_r;
         rx_eof <= (left_r == 7'h01);
         sh_r <= sh_r >> 1;
         left_r <= left_r - 7'h01;
         first_r <= 1'b0;
         busy <= (left_r != 7'h01);
      end
   end
   // Receiver rebuilds the frame in arrival order
   always @(posedge mclk) begin
      got_done <= ser_valid & ser_eof;
      if (ser_valid & ser_sof) begin
         got <= {79'h0, ser_bit};
         gi_r <= 7'h01;
      end else if (ser_valid) begin
         got[gi_r] <= ser_bit;
         gi_r <= gi_r + 7'h01;
      end
   end
endmodule // csmc_peer
`default_nettype wire

// File: tb_call_signal_message_codec.sv
// Purpose: Self-checking bench for the message codec
// Assumes: Peer model drives the receive lines
// Notes: Labels and payloads from a fixed-seed xorshift
`timescale 1ns/1ps
`default_nettype none
module tb_call_signal_message_codec;
   logic mclk = 1'b0, reset = 1'b1, tx_start = 1'b0, tx_final = 1'b0;
   logic tx_call_clear = 1'b0, tx_has_cc = 1'b0, tx_special_op = 1'b0;
   logic tx_to_incoming = 1'b0, tx_ec_known = 1'b0, tx_ec_in = 1'b0;
   logic tx_noc_known = 1'b0, tx_noc_in = 1'b0, cont_pending = 1'b0;
   logic [39:0] tx_label = 40'h0;
   logic [3:0] tx_group = 4'h0, tx_signal = 4'h0, tx_cc_len = 4'h0;
   logic [3:0] tx_digit_cnt = 4'h0;
   logic [127:0] tx_payload = 128'h0;
   logic [7:0] tx_pay_len = 8'h0;
   logic tx_ready, tx_refused, tx_holding, ser_bit, ser_valid, ser_sof;
   logic ser_eof, rx_bit, rx_valid, rx_sof, rx_eof, rx_msg_valid;
   logic rx_unrecog, rx_seize, rx_short, rx_pay_bit, rx_pay_valid;
   logic [39:0] rx_label;
   logic [3:0] rx_group, rx_signal, rx_class;
   logic p_go = 1'b0, p_slow = 1'b0, p_busy, got_done;
   logic [63:0] p_frame = 64'h0;
   logic [6:0] p_bits = 7'h0;
   logic [79:0] got;
   logic [31:0] seed = 32'h00016C44;
   int n_errors = 0, checks = 0, npay = 0;
   logic [15:0] pay_sh = 16'h0; // Last payload bits from the decoder
   csmc_codec u_csmc_codec (.mclk(mclk), .reset(reset), .tx_start(tx_start),
      .tx_label(tx_label), .tx_group(tx_group), .tx_signal(tx_signal),
      .tx_payload(tx_payload), .tx_pay_len(tx_pay_len), .tx_final(tx_final),
      .tx_call_clear(tx_call_clear), .tx_has_cc(tx_has_cc),
      .tx_special_op(tx_special_op), .tx_to_incoming(tx_to_incoming),
      .tx_cc_len(tx_cc_len), .tx_digit_cnt(tx_digit_cnt),
      .tx_ec_known(tx_ec_known), .tx_ec_in(tx_ec_in),
      .tx_noc_known(tx_noc_known), .tx_noc_in(tx_noc_in),
      .cont_pending(cont_pending), .tx_ready(tx_ready),
      .tx_refused(tx_refused), .tx_holding(tx_holding), .ser_bit(ser_bit),
      .ser_valid(ser_valid), .ser_sof(ser_sof), .ser_eof(ser_eof),
      .rx_bit(rx_bit), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof),
      .rx_label(rx_label), .rx_group(rx_group), .rx_signal(rx_signal),
      .rx_class(rx_class), .rx_msg_valid(rx_msg_valid),
      .rx_unrecog(rx_unrecog), .rx_seize(rx_seize), .rx_short(rx_short),
      .rx_pay_bit(rx_pay_bit), .rx_pay_valid(rx_pay_valid));
   csmc_peer u_csmc_peer (.mclk(mclk), .reset(reset), .go(p_go),
      .slow(p_slow), .frame(p_frame), .nbits(p_bits), .busy(p_busy),
      .rx_bit(rx_bit), .rx_valid(rx_valid), .rx_sof(rx_sof), .rx_eof(rx_eof),
      .ser_bit(ser_bit), .ser_valid(ser_valid), .ser_sof(ser_sof),
      .ser_eof(ser_eof), .got(got), .got_done(got_done));
   always #4 mclk = ~mclk;
   // Payload bits handed out by the decoder
   always @(posedge mclk) if (rx_pay_valid === 1'b1) npay <= npay + 1;
   // Payload data, first bit ends up lowest
   always @(posedge mclk)
      if (rx_pay_valid === 1'b1) pay_sh <= {rx_pay_bit, pay_sh[15:1]};
   function logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      rnd = seed;
   endfunction
   // Heading pairs the encoder may send
   function automatic logic ok_hdr(input logic [3:0] g, s);
      case (g)
         4'h4: ok_hdr = (s == 4'h1) || (s == 4'h2);
         4'h5: ok_hdr = (s != 4'h0 && s < 4'hA) || s == 4'hF;
         4'h6: ok_hdr = (s != 4'h0 && s < 4'h7) || s == 4'hF;
         default: ok_hdr = (s != 4'h0 && s < 4'h8);
      endcase
   endfunction
   task automatic chk(input string nm, input logic [79:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // One transmit request, then refusal or the whole frame checked
   task automatic send(input logic [3:0] g, s, input logic [31:0] pay,
         input logic [7:0] len, input logic ok, input logic [31:0] opay);
      logic [31:0] r;
      int n;
      r = rnd();
      do @(negedge mclk); while (tx_ready !== 1'b1);
      @(posedge mclk);
      tx_label <= {r, r[7:0]};
      tx_group <= g;
      tx_signal <= s;
      tx_payload <= {96'h0, pay};
      tx_pay_len <= len;
      tx_start <= 1'b1;
      @(posedge mclk);
      tx_start <= 1'b0;
      @(negedge mclk);
      chk("refused", 80'(tx_refused), 80'(!ok));
      if (ok) begin
         for (n = 0; n < 400 && got_done !== 1'b1; n++) @(negedge mclk);
         chk("header", 80'(got[47:0]), 80'({s, g, r, r[7:0]}));
         chk("payload", 80'(got[79:48]), 80'(opay));
      end
      @(posedge mclk);
   endtask
   // One frame from the peer, then the decoded header checked
   task automatic rx(input logic [3:0] g, s, c, input logic un, sz);
      logic [31:0] r;
      int n, p0;
      r = rnd();
      @(posedge mclk);
      p_frame <= {r[31:16], s, g, r, r[7:0]};
      p_bits <= 7'h40;
      p_slow <= r[0];
      p_go <= 1'b1;
      @(posedge mclk);
      p_go <= 1'b0;
      p0 = npay;
      for (n = 0; n < 300 && !(rx_msg_valid | rx_unrecog); n++)
         @(negedge mclk);
      chk("unrecog", 80'(rx_unrecog), 80'(un));
      chk("seize", 80'(rx_seize), 80'(sz));
      chk("rx head", 80'({rx_signal, rx_group, rx_label}),
         80'({s, g, r, r[7:0]}));
      if (!un) chk("class", 80'(rx_class), 80'(c));
      for (n = 0; n < 200 && p_busy; n++) @(negedge mclk);
      repeat (2) @(negedge mclk);
      chk("pay bits", 80'(npay - p0), un ? 80'h0 : 80'h10);
      if (!un) chk("pay data", 80'(pay_sh), 80'(r[31:16]));
      @(posedge mclk);
   endtask
   initial begin
      logic [31:0] pv;
      int n;
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      for (int g = 4; g < 8; g++) begin
         for (int s = 0; s < 16; s++) begin
            pv = rnd() & 32'h000000FF;
            send(4'(g), 4'(s), pv, 8'h08, ok_hdr(4'(g), 4'(s)), pv);
         end
      end
      $display("test heading table done");
      send(4'h1, 4'h3, 32'h55, 8'h08, 1'b0, 32'h0);
      tx_has_cc <= 1'b1;
      tx_digit_cnt <= 4'h3;
      send(4'h1, 4'h1, 32'h300, 8'h0C, 1'b0, 32'h0);
      tx_special_op <= 1'b1;
      send(4'h1, 4'h1, 32'h300, 8'h0C, 1'b1, 32'h300);
      tx_special_op <= 1'b0;
      tx_to_incoming <= 1'b1;
      tx_cc_len <= 4'h2;
      tx_digit_cnt <= 4'h5;
      tx_noc_known <= 1'b1;
      tx_noc_in <= 1'b1;
      tx_ec_in <= 1'b1;
      send(4'h1, 4'h1, 32'h05432100, 8'h1C, 1'b1, 32'h00054302);
      send(4'h1, 4'h4, 32'h9, 8'h08, 1'b1, 32'h9);
      cont_pending <= 1'b1;
      tx_final <= 1'b1;
      fork
         send(4'h1, 4'h3, 32'h77, 8'h08, 1'b1, 32'h77);
         begin
            repeat (30) @(negedge mclk);
            chk("holding", 80'(tx_holding), 80'h1);
            chk("held bits", 80'(ser_valid), 80'h0);
            @(posedge mclk);
            cont_pending <= 1'b0;
         end
      join
      tx_final <= 1'b0;
      tx_call_clear <= 1'b1;
      @(posedge mclk);
      tx_call_clear <= 1'b0;
      send(4'h1, 4'h3, 32'h1, 8'h08, 1'b0, 32'h0);
      $display("test address sending done");
      rx(4'h1, 4'h1, 4'h1, 1'b0, 1'b1);
      rx(4'h4, 4'h1, 4'h4, 1'b0, 1'b0);
      rx(4'h4, 4'h2, 4'h5, 1'b0, 1'b0);
      rx(4'h5, 4'hF, 4'h7, 1'b0, 1'b0);
      rx(4'h6, 4'hF, 4'h9, 1'b0, 1'b0);
      rx(4'h6, 4'h0, 4'h0, 1'b1, 1'b0);
      rx(4'h7, 4'h9, 4'h0, 1'b1, 1'b0);
      rx(4'h7, 4'h7, 4'hA, 1'b0, 1'b0);
      p_bits <= 7'h14;
      p_go <= 1'b1;
      @(posedge mclk);
      p_go <= 1'b0;
      for (n = 0; n < 100 && rx_short !== 1'b1; n++) @(negedge mclk);
      chk("short", 80'(rx_short), 80'h1);
      $display("test decoder done");
      complete_run();
   end
   // Watchdog well beyond the roughly 3000 cycles the tests take
   initial begin
      repeat (40000) @(posedge mclk);
      n_errors++;
      complete_run();
   end
endmodule // tb_call_signal_message_codec
`default_nettype wire
